// [hdl/pld_channel.v]
// one channel: level code decode and receive switch sequencing
`timescale 1ns/1ps
`default_nettype none
`include "pld_regs.vh"
module pld_channel (
	input  wire       clk_i,
	input  wire       arst_n_i,
	input  wire [2:0] code_i,
	input  wire       enable_n_i,
	input  wire       aux_allow_i,
	input  wire [1:0] ovl_sel_i,
	output reg  [7:0] gate_o,
	output reg        analog_ground_clamp_o,
	output reg  [2:0] tr_switch_o,
	output reg        rx_ready_o
);
	// cycles rounded up: a least time must not be cut short
	localparam integer OVL1 = ((1 * `PLD_OVL_STEP_NS * `PLD_CLK_MHZ) + 999) / 1000;
	localparam integer OVL2 = ((2 * `PLD_OVL_STEP_NS * `PLD_CLK_MHZ) + 999) / 1000;
	localparam integer OVL3 = ((3 * `PLD_OVL_STEP_NS * `PLD_CLK_MHZ) + 999) / 1000;
	localparam integer TON0 = ((`PLD_TON_BASE_NS * `PLD_CLK_MHZ) + 999) / 1000;
	localparam integer TON1 = (((`PLD_TON_BASE_NS + `PLD_TON_STEP_NS) * `PLD_CLK_MHZ) + 999) / 1000;
	localparam integer TON2 = (((`PLD_TON_BASE_NS + 2 * `PLD_TON_STEP_NS) * `PLD_CLK_MHZ) + 999) / 1000;
	localparam integer TON3 = (((`PLD_TON_BASE_NS + 3 * `PLD_TON_STEP_NS) * `PLD_CLK_MHZ) + 999) / 1000;

	reg  [4:0] cnt_q;
	reg  [4:0] ovl_cyc;
	reg  [4:0] ton_cyc;
	reg  [7:0] gate_d;
	reg        clamp_d;
	wire       rx_code;

	assign rx_code = ~enable_n_i & (code_i[1:0] == 2'h2);

	// overlap and turn-on lengths per select value
	always @* begin
		case (ovl_sel_i)
			// counts fit five bits, the upper bits of the integers are zero
			2'h0: begin
				ovl_cyc = 5'h00;
				ton_cyc = TON0[4:0];
			end
			2'h1: begin
				ovl_cyc = OVL1[4:0];
				ton_cyc = TON1[4:0];
			end
			2'h2: begin
				ovl_cyc = OVL2[4:0];
				ton_cyc = TON2[4:0];
			end
			default: begin
				ovl_cyc = OVL3[4:0];
				ton_cyc = TON3[4:0];
			end
		endcase
	end

	// gate order: p1 n1 p2 n2 aux_pmos aux_nmos p4 n4 from bit 0 up
	always @* begin
		gate_d  = 8'h00;
		clamp_d = 1'b0;
		case (code_i)
			`PLD_CODE_POS2: gate_d = {2'b00, 1'b1 & aux_allow_i, 1'b0, 4'b0100};
			`PLD_CODE_POS1: gate_d = 8'h01;
			`PLD_CODE_NEG2: gate_d = {2'b00, 1'b0, 1'b1 & aux_allow_i, 4'b1000};
			`PLD_CODE_NEG1: gate_d = 8'h02;
			`PLD_CODE_GND, `PLD_CODE_GND_RX: begin
				gate_d  = 8'hC0;
				clamp_d = 1'b1;
			end
			default: gate_d = 8'h00;
		endcase
		if (enable_n_i) begin
			gate_d  = 8'h00;
			clamp_d = 1'b0;
		end
	end

	// time since the receive path was requested; saturates
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q <= 5'h00;
		end else if (!rx_code) begin
			cnt_q <= 5'h00;
		end else if (cnt_q != 5'h1F) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	// registered switch drive; s2 terminates the receive output when not receiving
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gate_o                <= 8'h00;
			analog_ground_clamp_o <= 1'b0;
			tr_switch_o           <= 3'b010;
			rx_ready_o            <= 1'b0;
		end else begin
			gate_o                <= gate_d;
			analog_ground_clamp_o <= clamp_d;
			// s1 and s3 on at once, s2 held on for the overlap time
			tr_switch_o <= rx_code ? {1'b1, (cnt_q < ovl_cyc), 1'b1} : 3'b010;
			rx_ready_o  <= rx_code & (cnt_q >= ton_cyc - 5'h01);
		end
	end
endmodule
`default_nettype wire

// [hdl/pld_regs.vh]
// register map, field positions and timing constants for the pulser level decoder
// What this block does
// - decode each 3-bit level code into switch states
// - output enable off forces everything safe
// - aux clamps only in current mode 3
// - current select sets second-rail drive current
// - overlap select sets receive switch overlap
// - receive ready after 400 to 700 ns
// - edge delay select shifts sampling edge
// - thermal protection pulls thermal flag low
// - thermal flag is open-drain, pulled up outside
`ifndef PLD_REGS_VH
`define PLD_REGS_VH

// apb byte offsets
`define PLD_CTRL_OFF        12'h000
`define PLD_STATUS_OFF      12'h004
`define PLD_CODES_OFF       12'h008

// control register fields and reset value
`define PLD_CTRL_CUR_LSB    0
`define PLD_CTRL_OVL_LSB    2
`define PLD_CTRL_EDGE_LSB   4
`define PLD_CTRL_RST        6'h03

// status register fields
`define PLD_STAT_THERM_BIT  0
`define PLD_STAT_RDY_LSB    4

// level codes
`define PLD_CODE_HIZ        3'h0
`define PLD_CODE_POS2       3'h1
`define PLD_CODE_RX         3'h2
`define PLD_CODE_POS1       3'h3
`define PLD_CODE_GND        3'h4
`define PLD_CODE_NEG2       3'h5
`define PLD_CODE_GND_RX     3'h6
`define PLD_CODE_NEG1       3'h7

// timing
`define PLD_CLK_MHZ         25
`define PLD_OVL_STEP_NS     100
`define PLD_TON_BASE_NS     400
`define PLD_TON_STEP_NS     100
`define PLD_EDGE_STEP_PS    11'h1F4
`define PLD_CUR_STEP_MA     500

// thermal trip point and hysteresis in degrees C
`define PLD_THERM_TRIP_C    8'h6E
`define PLD_THERM_HYST_C    8'h0A

`endif

// [hdl/pld_top.v]
// four-channel pulser level decoder with apb control and thermal flag
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pld_regs.vh"
module pld_top (
	input  wire        clk_i,
	input  wire        arst_n_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	input  wire [11:0] channel_level_code_i,
	input  wire        output_enable_n_i,
	input  wire [7:0]  die_temp_i,
	output wire [31:0] switch_gate_o,
	output wire [3:0]  analog_ground_clamp_o,
	output wire [11:0] tr_switch_o,
	output wire [3:0]  rx_ready_o,
	output reg  [2:0]  drive_current_steps_o,
	output reg  [10:0] clock_edge_delay_ps_o,
	output wire        thermal_flag_n_o,
	output wire        thermal_flag_n_oe_o
);
	reg  [5:0]  ctrl_q;
	reg         therm_q;
	wire [1:0]  drive_current_select;
	wire [1:0]  rx_overlap_select;
	wire        clock_edge_delay_select_hi;
	wire        clock_edge_delay_select_lo;
	wire        addr_ok;
	wire        setup;
	wire        access;
	wire [7:0]  release_c;

	assign drive_current_select       = ctrl_q[`PLD_CTRL_CUR_LSB +: 2];
	assign rx_overlap_select          = ctrl_q[`PLD_CTRL_OVL_LSB +: 2];
	assign clock_edge_delay_select_hi = ctrl_q[`PLD_CTRL_EDGE_LSB + 1];
	assign clock_edge_delay_select_lo = ctrl_q[`PLD_CTRL_EDGE_LSB];

	// apb decode; the slave never waits, so every access ends in one access cycle
	assign setup     = psel_i & ~penable_i;
	assign access    = psel_i & penable_i;
	assign addr_ok   = (paddr_i == `PLD_CTRL_OFF) | (paddr_i == `PLD_STATUS_OFF) | (paddr_i == `PLD_CODES_OFF);
	assign pready_o  = 1'b1;
	assign pslverr_o = access & ~addr_ok;

	// control register: only writable location, status and codes are read only
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= `PLD_CTRL_RST;
		end else if (access & pwrite_i & (paddr_i == `PLD_CTRL_OFF)) begin
			ctrl_q <= pwdata_i[5:0];
		end
	end

	// read data captured in the setup cycle so it comes straight from a flop
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prdata_o <= 32'h00000000;
		end else if (setup & ~pwrite_i) begin
			case (paddr_i)
				`PLD_CTRL_OFF:   prdata_o <= {26'h0000000, ctrl_q};
				`PLD_STATUS_OFF: prdata_o <= {24'h000000, rx_ready_o, 3'h0, therm_q};
				`PLD_CODES_OFF:  prdata_o <= {20'h00000, channel_level_code_i};
				default:         prdata_o <= 32'h00000000;
			endcase
		end
	end

	// hysteresis keeps the flag from chattering around the trip point
	assign release_c = `PLD_THERM_TRIP_C - `PLD_THERM_HYST_C;
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			therm_q <= 1'b0;
		end else if (!therm_q && die_temp_i >= `PLD_THERM_TRIP_C) begin
			therm_q <= 1'b1;
		end else if (therm_q && die_temp_i <= release_c) begin
			therm_q <= 1'b0;
		end
	end

	// open drain: only ever pull low, the board pull-up gives the idle high
	assign thermal_flag_n_o    = 1'b0;
	assign thermal_flag_n_oe_o = therm_q;

	// drive strength in 0.5 A steps and edge shift in picoseconds
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			drive_current_steps_o <= 3'h0;
			clock_edge_delay_ps_o <= 11'h000;
		end else begin
			drive_current_steps_o <= {1'b0, drive_current_select} + 3'h1;
			clock_edge_delay_ps_o <= {clock_edge_delay_select_hi, clock_edge_delay_select_lo} * `PLD_EDGE_STEP_PS;
		end
	end

	// one decoder per channel; code bit 0 is the least significant
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
			pld_channel u_ch (
				.clk_i                 (clk_i),
				.arst_n_i              (arst_n_i),
				.code_i                (channel_level_code_i[3*ch +: 3]),
				.enable_n_i            (output_enable_n_i),
				.aux_allow_i           (drive_current_select == 2'h3),
				.ovl_sel_i             (rx_overlap_select),
				.gate_o                (switch_gate_o[8*ch +: 8]),
				.analog_ground_clamp_o (analog_ground_clamp_o[ch]),
				.tr_switch_o           (tr_switch_o[3*ch +: 3]),
				.rx_ready_o            (rx_ready_o[ch])
			);
		end
	endgenerate
endmodule
`default_nettype wire

// [tb/pld_asserts.sv]
// concurrent checks on the level decoder ports
`timescale 1ns/1ps
`default_nettype none
module pld_asserts (
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	input wire logic [11:0] channel_level_code_i,
	input wire logic        output_enable_n_i,
	input wire logic [7:0]  die_temp_i,
	input wire logic [31:0] switch_gate_o,
	input wire logic [3:0]  analog_ground_clamp_o,
	input wire logic [11:0] tr_switch_o,
	input wire logic [3:0]  rx_ready_o,
	input wire logic [2:0]  drive_current_steps_o,
	input wire logic        thermal_flag_n_o,
	input wire logic        thermal_flag_n_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// channel 0 stands for all four, each has an identical decoder
	wire [2:0] c0 = channel_level_code_i[2:0];
	wire       on = !output_enable_n_i;
	// eight edges of receive code is still short of the fastest turn-on
	sequence rx_start;
		!(on && c0[1:0] == 2'h2) ##1 (on && c0[1:0] == 2'h2) [*8];
	endsequence
	chk_hiz_all_off: assert property (on && c0 == 3'h0 |=> switch_gate_o[7:0] == 8'h00)
		else $error("hiz code drives a switch");
	chk_pos1_bit_order: assert property (on && c0 == 3'h3 |=> switch_gate_o[7:0] == 8'h01)
		else $error("code 3 wrong switch");
	chk_gnd_clamp_on: assert property (on && c0 == 3'h4 |=> switch_gate_o[7:0] == 8'hC0 && analog_ground_clamp_o[0])
		else $error("ground clamp missing");
	chk_disable_safe: assert property (!on |=> switch_gate_o == 32'h0 && analog_ground_clamp_o == 4'h0
		&& tr_switch_o == 12'h492 && rx_ready_o == 4'h0)
		else $error("disabled outputs not safe");
	// the extra past term covers the edge where the current mode changes
	chk_aux_clamps_off: assert property (drive_current_steps_o != 3'h4 && $past(drive_current_steps_o) != 3'h4
		|-> (switch_gate_o & 32'h30303030) == 32'h0)
		else $error("aux clamp on outside mode 3");
	chk_rx_not_early: assert property (rx_start |-> !rx_ready_o[0])
		else $error("receive ready too early");
	chk_therm_trip: assert property (die_temp_i >= 8'h6E |=> thermal_flag_n_oe_o)
		else $error("thermal flag not raised");
	chk_therm_hold: assert property (thermal_flag_n_oe_o && die_temp_i > 8'h64 |=> thermal_flag_n_oe_o)
		else $error("thermal flag dropped early");
	chk_flag_open_drain: assert property (thermal_flag_n_o == 1'b0)
		else $error("thermal flag drives high");
endmodule
bind pld_top pld_asserts pld_asserts_i (
	.clk_i                 (clk_i),
	.arst_n_i              (arst_n_i),
	.channel_level_code_i  (channel_level_code_i),
	.output_enable_n_i     (output_enable_n_i),
	.die_temp_i            (die_temp_i),
	.switch_gate_o         (switch_gate_o),
	.analog_ground_clamp_o (analog_ground_clamp_o),
	.tr_switch_o           (tr_switch_o),
	.rx_ready_o            (rx_ready_o),
	.drive_current_steps_o (drive_current_steps_o),
	.thermal_flag_n_o      (thermal_flag_n_o),
	.thermal_flag_n_oe_o   (thermal_flag_n_oe_o)
);
`default_nettype wire

// [tb/pld_ctl_model.sv]
// transmit controller model: grounds a channel before each transmit burst
`timescale 1ns/1ps
`default_nettype none
module pld_ctl_model (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic [11:0] req_i,
	output var  logic [11:0] code_o
);
	logic [1:0] age_q [4];
	// odd codes transmit; three ground edges give 120 ns, bit 0 is the lsb
	always_comb
		for (int n = 0; n < 4; n++)
			code_o[3*n+:3] = (req_i[3*n] && age_q[n] != 2'h3) ? 3'h4 : req_i[3*n+:3];
	// count ground edges, saturating so a running burst keeps going
	always_ff @(posedge clk_i or negedge arst_n_i)
		for (int n = 0; n < 4; n++)
			if (!arst_n_i)
				age_q[n] <= 2'h0;
			else if (code_o[3*n+:3] == 3'h4 && age_q[n] != 2'h3)
				age_q[n] <= age_q[n] + 2'h1;
			else if (!req_i[3*n])
				age_q[n] <= (code_o[3*n+:3] == 3'h4) ? 2'h3 : 2'h0;
endmodule
`default_nettype wire

// [tb/pld_top_tb.sv]
// self-checking bench for the pulser level decoder
`timescale 1ns/1ps
`default_nettype none
module pld_top_tb;
	logic clk_i = 0, arst_n_i = 0, psel = 0, pen = 0, pwr = 0, oe_n = 0, ev;
	logic [11:0] paddr = 12'h0, req = 12'h0;
	logic [31:0] pwd = 32'h0, rd;
	logic [7:0] temp = 8'h19;
	wire [11:0] code, trs;
	wire [31:0] prd, sg;
	wire [3:0] cl, rdy;
	wire [2:0] stp;
	wire [10:0] dly;
	wire rdyo, err, fl, floe;
	int n_mismatch = 0, n_compared = 0, seed = 45, k, n, i, m;
	int ton[4] = '{10, 13, 15, 18};
	int ovl[4] = '{0, 3, 5, 8};
	pld_ctl_model pld_ctl_model_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .code_o(code));
	pld_top pld_top_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdyo), .pslverr_o(err),
		.channel_level_code_i(code), .output_enable_n_i(oe_n), .die_temp_i(temp), .switch_gate_o(sg),
		.analog_ground_clamp_o(cl), .tr_switch_o(trs), .rx_ready_o(rdy), .drive_current_steps_o(stp),
		.clock_edge_delay_ps_o(dly), .thermal_flag_n_o(fl), .thermal_flag_n_oe_o(floe));
	always #20 clk_i = ~clk_i;
	task automatic tick(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer; waits for pready at a rising edge before releasing
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		do @(posedge clk_i); while (rdyo !== 1'b1);
		rd = prd;
		ev = err;
		psel <= 1'b0;
		pen <= 1'b0;
		tick(1);
	endtask
	function automatic logic [7:0] eg(input logic [2:0] c, input logic a);
		case (c)
			3'h1: return a ? 8'h24 : 8'h04;
			3'h3: return 8'h01;
			3'h4, 3'h6: return 8'hC0;
			3'h5: return a ? 8'h18 : 8'h08;
			3'h7: return 8'h02;
			default: return 8'h00;
		endcase
	endfunction
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// watchdog sized well past the few hundred cycles the run needs
	initial begin
		#400000;
		n_mismatch++;
		results();
	end
	initial begin
		tick(2);
		arst_n_i <= 1'b1;
		apb(0, 12'h000, 32'h0);
		check("ctrl_rst", rd, 32'h3);
		apb(0, 12'h00C, 32'h0);
		check("unmapped", {rd[30:0], ev}, 32'h1);
		for (k = 0; k < 4; k++) begin
			apb(1, 12'h000, 32'(k * 21));
			check("cur", {29'h0, stp}, 32'(k + 1));
			check("dly", {21'h0, dly}, 32'(k * 500));
			// every code on all channels first, then random mixes
			for (i = 0; i < 10; i++) begin
				req <= (i < 8) ? 12'(i * 12'h249) : 12'($random(seed));
				tick(5);
				for (n = 0; n < 4; n++)
					check("gate", {cl[n], sg[8*n+:8]}, {code[3*n+2] & ~code[3*n], eg(code[3*n+:3], k == 3)});
				apb(0, 12'h008, 32'h0);
				check("codes", rd, {20'h0, code});
			end
			req <= 12'h000;
			tick(3);
			req <= 12'h492;
			m = 0;
			for (n = 0; rdy[0] !== 1'b1 && n < 30; n++) begin
				tick(1);
				if (n == 0)
					check("overlap", {31'h0, trs[1]}, 32'(k > 0));
				m += trs[1];
			end
			check("ovl_len", m, ovl[k]);
			check("ton", 32'(n), 32'(ton[k]));
			check("rx_sw", {29'h0, trs[2:0]}, 32'h5);
			apb(0, 12'h004, 32'h0);
			check("rdy_stat", {28'h0, rd[7:4]}, 32'hF);
			oe_n <= 1'b1;
			tick(2);
			check("safe", sg | {12'h0, rdy, cl, trs}, 32'h492);
			oe_n <= 1'b0;
		end
		// mid-run reset: outputs fall back to safe values, control to mode 3
		apb(1, 12'h000, 32'h0);
		arst_n_i <= 1'b0;
		tick(1);
		check("rst_gate", sg, 32'h0);
		check("rst_sw", {16'h0, rdy, trs}, 32'h492);
		check("rst_cur", {18'h0, stp, dly}, 32'h0);
		arst_n_i <= 1'b1;
		tick(1);
		check("rst_mode", {29'h0, stp}, 32'h4);
		apb(0, 12'h000, 32'h0);
		check("ctrl_rst2", rd, 32'h3);
		// trip, hold inside the hysteresis band, then release
		for (i = 0; i < 4; i++) begin
			temp <= (i == 0) ? 8'h6D : (i == 1) ? 8'h6E : (i == 2) ? 8'h65 : 8'h64;
			tick(2);
			apb(0, 12'h004, 32'h0);
			check("therm", {30'h0, rd[0], floe}, (i == 1 || i == 2) ? 32'h3 : 32'h0);
		end
		results();
	end
endmodule
`default_nettype wire
